// [src/parf_pkg.sv]
// Purpose: shared constants for the position/alarm readout framer
// Assumes: 250 MHz clk_sys, APB register access with 32-bit data
// Notes: frame is 56 bits, sent msb first on a serial line
package parf_pkg;
  localparam int unsigned FRAME_BITS = 56;
  localparam int unsigned PAYLOAD_BITS = 48;
  localparam int unsigned PAYLOAD_BYTES = 6;
  localparam logic [7:0] STATUS_DEF_MASK = 8'h1f;
  localparam logic [7:0] EMERGENCY_STOP_ALARM_CODE = 8'h68;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned READ_MIN_MS = 500;
  localparam int unsigned READ_MAX_MS = 1000;
  // one bit period: frame spread over the minimum read time
  localparam int unsigned BIT_CYCLES_DEF =
    (CLK_HZ / 1000) * READ_MIN_MS / FRAME_BITS;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_POS = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_ALARM = 8'h0c;
  localparam logic [7:0] ADDR_CSUM = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_BUSY_BIT = 1;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_ESTOP_BIT = 1;
  localparam int unsigned IRQ_BITS = 2;
  typedef enum logic [1:0] {PARF_IDLE, PARF_LOAD, PARF_SHIFT} parf_state_t;
endpackage : parf_pkg

// [src/parf_csum.sv]
// Purpose: checksum of the 48-bit payload
// Assumes: payload ordered position, status, alarm
// Notes: registered output, one cycle of latency
`timescale 1ns/10ps
module parf_csum
  import parf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [PAYLOAD_BITS-1:0] payload,
  output logic [7:0] csum
);
  logic [7:0] next_csum;
  always_comb begin
    next_csum = 8'h00;
    for (int i = 0; i < PAYLOAD_BYTES; i++) begin
      next_csum = next_csum + payload[i*8 +: 8];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      csum <= 8'h00;
    end else begin
      csum <= next_csum;
    end
  end
endmodule : parf_csum

// [src/parf_shift.sv]
// Purpose: msb-first shifter for the 56-bit frame
// Assumes: load and tick pulses come from the framer control
// Notes: data held stable between ticks
`timescale 1ns/10ps
module parf_shift
  import parf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic load,
  input wire logic tick,
  input wire logic [FRAME_BITS-1:0] frame,
  output logic sdata
);
  logic [FRAME_BITS-1:0] sreg;
  logic [FRAME_BITS-1:0] next_sreg;
  always_comb begin
    next_sreg = sreg;
    if (load) begin
      next_sreg = frame;
    end else if (tick) begin
      next_sreg = {sreg[FRAME_BITS-2:0], 1'b0};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sreg <= '0;
    end else begin
      sreg <= next_sreg;
    end
  end
  assign sdata = sreg[FRAME_BITS-1];
endmodule : parf_shift

// [src/parf_top.sv]
// Purpose: build and serialise the position/status/alarm readout frame
// Assumes: inputs from same-clock logic; APB master keeps protocol
// Notes: pslverr never set; unmapped reads return zero
`timescale 1ns/10ps
module parf_top
  import parf_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] position,
  input wire logic subsys_overflow,
  input wire logic backup_overspeed,
  input wire logic position_lost,
  input wire logic absolute_position_backup_low,
  input wire logic battery_missing,
  input wire logic [7:0] alarm_code,
  input wire logic estop_active,
  output logic frame_data,
  output logic frame_valid,
  output logic irq
);
  parf_state_t state, next_state;
  logic [31:0] bit_cnt, next_bit_cnt;
  logic [5:0] bits_left, next_bits_left;
  logic [31:0] pos_snap, next_pos_snap;
  logic [7:0] stat_snap, next_stat_snap;
  logic [7:0] alarm_snap, next_alarm_snap;
  logic [IRQ_BITS-1:0] irq_stat, next_irq_stat;
  logic [IRQ_BITS-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_frame_valid, next_frame_data, next_irq;
  logic [7:0] csum;
  logic [7:0] status_now;
  logic [7:0] alarm_now;
  logic sdata;
  logic shift_load, shift_tick, wr_acc, rd_acc, start_req, done_ev;
  logic estop_q, estop_rise;
  logic next_pslverr;
  logic [31:0] valid_run, next_valid_run;

  // one clock domain throughout, so all checks share one clocking
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  assign status_now = {3'b000, battery_missing, absolute_position_backup_low,
                       position_lost, backup_overspeed, subsys_overflow}
                      & STATUS_DEF_MASK;
  assign alarm_now = estop_active ? EMERGENCY_STOP_ALARM_CODE : alarm_code;

  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && penable && !pwrite && pready;
  assign start_req = wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_START_BIT];
  assign shift_load = state == PARF_LOAD;
  assign shift_tick = state == PARF_SHIFT && bit_cnt == BIT_CYCLES - 1;
  assign done_ev = shift_tick && bits_left == 6'd1;
  assign estop_rise = estop_active && !estop_q;

  parf_csum u_csum (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .payload({next_pos_snap, next_stat_snap, next_alarm_snap}),
    .csum(csum)
  );

  parf_shift u_shift (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(shift_load),
    .tick(shift_tick),
    .frame({pos_snap, stat_snap, alarm_snap, csum}),
    .sdata(sdata)
  );

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_bits_left = bits_left;
    next_pos_snap = pos_snap;
    next_stat_snap = stat_snap;
    next_alarm_snap = alarm_snap;
    case (state)
      PARF_IDLE: begin
        if (start_req) begin
          next_pos_snap = position;
          next_stat_snap = status_now;
          next_alarm_snap = alarm_now;
          next_state = PARF_LOAD;
        end
      end
      // snapshot and checksum stand now; the shifter takes them here
      PARF_LOAD: begin
        next_bit_cnt = '0;
        next_bits_left = 6'(FRAME_BITS);
        next_state = PARF_SHIFT;
      end
      PARF_SHIFT: begin
        if (bit_cnt == BIT_CYCLES - 1) begin
          next_bit_cnt = '0;
          next_bits_left = bits_left - 6'd1;
          if (bits_left == 6'd1) begin
            next_state = PARF_IDLE;
          end
        end else begin
          next_bit_cnt = bit_cnt + 32'd1;
        end
      end
      default: next_state = PARF_IDLE;
    endcase
  end

  // the checksum is fed from the next snapshot, so it lands with it
  always_comb begin
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_prdata = 32'h0000_0000;
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    if (wr_acc && paddr == ADDR_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata[IRQ_BITS-1:0];
    end
    if (wr_acc && paddr == ADDR_IRQ_MASK) begin
      next_irq_mask = pwdata[IRQ_BITS-1:0];
    end
    // set wins over a simultaneous clear
    if (done_ev) begin
      next_irq_stat[IRQ_DONE_BIT] = 1'b1;
    end
    if (estop_rise) begin
      next_irq_stat[IRQ_ESTOP_BIT] = 1'b1;
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL: next_prdata[CTRL_BUSY_BIT] = state != PARF_IDLE;
        ADDR_POS: next_prdata = pos_snap;
        ADDR_STAT: next_prdata = {24'h000000, stat_snap};
        ADDR_ALARM: next_prdata = {24'h000000, alarm_snap};
        ADDR_CSUM: next_prdata = {24'h000000, csum};
        ADDR_IRQ_STAT: next_prdata[IRQ_BITS-1:0] = irq_stat;
        ADDR_IRQ_MASK: next_prdata[IRQ_BITS-1:0] = irq_mask;
        default: next_prdata = 32'h0000_0000;
      endcase
    end else if (!(psel && penable)) begin
      next_prdata = 32'h0000_0000;
    end else begin
      next_prdata = prdata;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
    // the last bit stands its full period, like every other bit
    next_frame_valid = state == PARF_SHIFT;
    next_frame_data = state == PARF_SHIFT ? sdata : 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= PARF_IDLE;
      bit_cnt <= '0;
      bits_left <= '0;
      pos_snap <= '0;
      stat_snap <= 8'h00;
      alarm_snap <= 8'h00;
      irq_stat <= '0;
      irq_mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      valid_run <= '0;
      frame_valid <= 1'b0;
      frame_data <= 1'b0;
      irq <= 1'b0;
      estop_q <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      bits_left <= next_bits_left;
      pos_snap <= next_pos_snap;
      stat_snap <= next_stat_snap;
      alarm_snap <= next_alarm_snap;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      valid_run <= next_valid_run;
      frame_valid <= next_frame_valid;
      frame_data <= next_frame_data;
      irq <= next_irq;
      estop_q <= estop_active;
    end
  end
  // helper for the frame length check: counts cycles of frame_valid
  always_comb begin
    next_valid_run = '0;
    if (frame_valid) begin
      next_valid_run = valid_run + 32'd1;
    end
  end

  // captured fields
  AST_STAT_HIGH_ZERO: assert property (
    stat_snap[7:5] == 3'b000)
    else $error("status upper bits set");
  AST_ESTOP_CODE: assert property (
    (state == PARF_IDLE && start_req && estop_active) |=>
    alarm_snap == 8'h68) else $error("estop code wrong");
  AST_ALARM_PASS: assert property (
    (state == PARF_IDLE && start_req && !estop_active) |=>
    alarm_snap == $past(alarm_code)) else $error("alarm code lost");
  AST_STAT_MAP: assert property (
    (state == PARF_IDLE && start_req) |=>
    stat_snap[4:0] == {$past(battery_missing),
    $past(absolute_position_backup_low), $past(position_lost),
    $past(backup_overspeed), $past(subsys_overflow)})
    else $error("status map wrong");
  AST_POS_SNAP: assert property (
    (state == PARF_IDLE && start_req) |=> pos_snap == $past(position))
    else $error("position not captured");
  AST_CSUM: assert property (
    state == PARF_SHIFT |-> csum == 8'(pos_snap[31:24] + pos_snap[23:16]
    + pos_snap[15:8] + pos_snap[7:0] + stat_snap + alarm_snap))
    else $error("checksum mismatch");
  AST_BUSY_REFUSE: assert property (
    (state == PARF_SHIFT && start_req) |=> $stable(pos_snap))
    else $error("start accepted while busy");

  // frame timing on the serial line
  AST_FIRST_BIT: assert property (
    state == PARF_LOAD |=> ##1 frame_data == pos_snap[31])
    else $error("first bit not position msb");
  AST_LAST_BIT: assert property (
    (state == PARF_SHIFT && bits_left == 6'd1) |-> sdata == csum[0])
    else $error("last bit not checksum lsb");
  AST_START_LATENCY: assert property (
    (state == PARF_IDLE && start_req) |-> ##3 frame_valid)
    else $error("frame did not start on time");
  AST_LOAD_ONE: assert property (
    state == PARF_LOAD |=> state == PARF_SHIFT)
    else $error("load state lasted too long");
  AST_FRAME_LEN: assert property (
    $fell(frame_valid) |-> valid_run == FRAME_BITS * BIT_CYCLES)
    else $error("frame length wrong");
  AST_IDLE_QUIET: assert property (
    state == PARF_IDLE |=> !frame_valid && !frame_data)
    else $error("frame line not quiet while idle");
  AST_DATA_LOW: assert property (
    !frame_valid |-> !frame_data)
    else $error("frame data outside frame");

  // register bus answers
  AST_PREADY_PULSE: assert property (
    pready |=> !pready)
    else $error("pready held too long");
  AST_PREADY_SETUP: assert property (
    (psel && !penable) |=> pready)
    else $error("pready missing after setup");
  AST_PRDATA_IDLE: assert property (
    !psel |=> prdata == 32'h0000_0000)
    else $error("prdata not cleared");
  AST_UNMAPPED: assert property (
    (psel && !penable && !pwrite && paddr > ADDR_IRQ_MASK) |=>
    prdata == 32'h0000_0000) else $error("unmapped read not zero");
  AST_NO_SLVERR: assert property (
    !pslverr) else $error("pslverr raised");

  // interrupt flags
  AST_IRQ_LEVEL: assert property (
    irq == |(irq_stat & irq_mask))
    else $error("irq level wrong");
  AST_IRQ_DONE: assert property (
    done_ev |=> irq_stat[IRQ_DONE_BIT])
    else $error("done not flagged");
  AST_IRQ_ESTOP: assert property (
    estop_rise |=> irq_stat[IRQ_ESTOP_BIT])
    else $error("estop not flagged");
  AST_IRQ_CLEAR: assert property (
    (wr_acc && paddr == ADDR_IRQ_STAT && pwdata[IRQ_DONE_BIT] && !done_ev)
    |=> !irq_stat[IRQ_DONE_BIT]) else $error("done flag not cleared");

  CV_FRAME: cover property (done_ev);
  CV_ESTOP: cover property (start_req && estop_active);
  CV_IRQ: cover property (irq);
  CV_BUSY_REFUSE: cover property (state == PARF_SHIFT && start_req);
  CV_READ: cover property (rd_acc && paddr == ADDR_CSUM);
endmodule : parf_top

// [verif/parf_host_model.sv]
// Purpose: host side that reads and checks the serial readout frame
// Assumes: one frame bit per BIT_CYCLES cycles while frame_valid is high
// Notes: samples each bit in its first cycle, where it has just settled
`timescale 1ns/10ps
module parf_host_model #(
  parameter int unsigned BIT_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic frame_data,
  input wire logic frame_valid,
  output logic [55:0] frame_word,
  output logic done,
  output logic csum_ok,
  output int unsigned nbits
);
  logic [55:0] shreg;
  logic was_valid;
  int unsigned cnt;
  function automatic logic [7:0] byte_sum(input logic [47:0] p);
    byte_sum = 8'h00;
    for (int i = 0; i < 6; i++) byte_sum += p[8*i +: 8];
  endfunction : byte_sum
  always_ff @(posedge clk_sys) begin
    done <= 1'b0;
    was_valid <= reset_n & frame_valid;
    if (!reset_n) begin
      cnt <= 0;
      nbits <= 0;
      csum_ok <= 1'b0;
      frame_word <= '0;
    end else if (frame_valid) begin
      if (cnt == 0) begin
        shreg <= {shreg[54:0], frame_data};
        nbits <= (was_valid ? nbits : 0) + 1;
      end
      cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
    end else begin
      cnt <= 0;
      if (was_valid) begin
        done <= 1'b1;
        frame_word <= shreg;
        csum_ok <= (byte_sum(shreg[55:8]) == shreg[7:0]);
      end
    end
  end
endmodule : parf_host_model

// [verif/test_position_alarm_readout_frame.sv]
// Purpose: self-checking bench for the readout framer
// Assumes: BIT_CYCLES shortened to 4 so a frame is 224 cycles
// Notes: random frames plus the all-ones and estop corner cases
`timescale 1ns/10ps
module test_position_alarm_readout_frame;
  import parf_pkg::*;
  logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, alarm_code = 8'h00;
  logic [31:0] pwdata = 32'h0, position = 32'h0, prdata, rd;
  logic pready, pslverr, frame_data, frame_valid, irq, done, csum_ok;
  logic subsys_overflow = 0, backup_overspeed = 0, position_lost = 0;
  logic absolute_position_backup_low = 0, battery_missing = 0;
  logic estop_active = 0, prev_es = 0;
  logic [1:0] mask;
  logic [55:0] frame_word;
  int unsigned nbits;
  int mismatches = 0, comparisons = 0;

  always #2 clk_sys = ~clk_sys;

  parf_top #(.BIT_CYCLES(4)) parf_top_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .position(position),
    .subsys_overflow(subsys_overflow), .backup_overspeed(backup_overspeed),
    .position_lost(position_lost),
    .absolute_position_backup_low(absolute_position_backup_low),
    .battery_missing(battery_missing), .alarm_code(alarm_code),
    .estop_active(estop_active), .frame_data(frame_data),
    .frame_valid(frame_valid), .irq(irq));
  parf_host_model #(.BIT_CYCLES(4)) parf_host_model_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .frame_data(frame_data), .frame_valid(frame_valid),
    .frame_word(frame_word), .done(done), .csum_ok(csum_ok), .nbits(nbits));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 50, 1);
  endtask : apb

  function automatic logic [7:0] exp_sum(input logic [47:0] p);
    exp_sum = 8'h00;
    for (int i = 0; i < 6; i++) exp_sum += p[8*i +: 8];
  endfunction : exp_sum

  task automatic send_frame(input logic [31:0] pos, input logic [4:0] st,
                            input logic [7:0] al, input logic es);
    logic [7:0] ea;
    logic [47:0] pl;
    logic [1:0] stat;
    int n;
    ea = es ? 8'h68 : al;
    pl = {pos, 3'b000, st, ea};
    stat = {es & ~prev_es, 1'b1};
    mask = 2'($urandom);
    apb(1, ADDR_IRQ_MASK, {30'h0, mask}, rd);
    @(posedge clk_sys);
    position <= pos;
    {battery_missing, absolute_position_backup_low, position_lost,
     backup_overspeed, subsys_overflow} <= st;
    alarm_code <= al;
    estop_active <= es;
    prev_es = es;
    apb(1, ADDR_CTRL, 32'h1, rd);
    apb(1, ADDR_CTRL, 32'h1, rd);
    apb(0, ADDR_CTRL, 32'h0, rd);
    chk(rd[CTRL_BUSY_BIT], 1);
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 1000, 1);
    chk(frame_word, {pl, exp_sum(pl)});
    chk({csum_ok, nbits[7:0]}, {1'b1, 8'd56});
    repeat (6) @(posedge clk_sys);
    chk({frame_valid, frame_data}, 2'b00);
    apb(0, ADDR_POS, 32'h0, rd);
    chk(rd, pos);
    apb(0, ADDR_STAT, 32'h0, rd);
    chk(rd, {27'h0, st});
    apb(0, ADDR_ALARM, 32'h0, rd);
    chk(rd, {24'h0, ea});
    apb(0, ADDR_CSUM, 32'h0, rd);
    chk(rd, {24'h0, exp_sum(pl)});
    apb(0, ADDR_IRQ_STAT, 32'h0, rd);
    chk({rd, irq}, {30'h0, stat, |(stat & mask)});
    apb(1, ADDR_IRQ_STAT, 32'h3, rd);
    @(posedge clk_sys);
    chk(irq, 0);
  endtask : send_frame

  initial begin
    void'($urandom(32'hafe9));
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(0, ADDR_IRQ_MASK, 32'h0, rd);
    chk({rd, pslverr, irq}, 34'h0);
    apb(1, 8'h1c, 32'hffffffff, rd);
    apb(0, 8'h1c, 32'h0, rd);
    chk(rd, 32'h0);
    send_frame(32'd12345, 5'h00, 8'h00, 1'b1);
    send_frame(32'hffffffff, 5'h1f, 8'hff, 1'b0);
    for (int i = 0; i < 8; i++) begin
      send_frame($urandom, 5'($urandom), 8'($urandom), 1'($urandom));
    end
    give_verdict();
  end

  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule : test_position_alarm_readout_frame
